// File: rtl/hlp_pkg.sv
package hlp_pkg;
   // -----------------------------------------------------------------
   // Configuration byte layout
   // -----------------------------------------------------------------
   localparam int BIT_LPM_DIS   = 5;
   localparam int BIT_RESERVED_BIT_ONE  = 4;
   localparam int BIT_GROUPED   = 3;
   localparam int BIT_RPT_OFF   = 2;
   localparam int BIT_TMO_OVR   = 1;
   localparam int BIT_RESERVED_BIT_ZERO = 0;
   localparam logic [7:0] CFG_RESET    = 8'h10;
   localparam logic [7:0] CFG_WR_MASK  = 8'h2e;
   localparam logic [7:0] CFG_FIX_ONE  = 8'h10;
   localparam logic [7:0] TMO_MAX      = 8'hff;
   localparam logic [7:0] TMO_ZERO     = 8'h00;
   localparam int NUM_PORTS = 4;
   typedef enum logic [1:0] {LPM_NORMAL, LPM_FORCED} hlp_lpm_t;
endpackage : hlp_pkg

// File: rtl/hlp_timeout_map.sv
`timescale 1ns/1ps
module hlp_timeout_map
   import hlp_pkg::*;
(
   // Control
   input  wire logic       override,
   // Timeout values
   input  wire logic [7:0] host_timeout,
   output logic      [7:0] used_timeout
);
   always_comb begin
      if (!override)
         used_timeout = host_timeout;
      else if (host_timeout == TMO_ZERO)
         used_timeout = TMO_ZERO;
      else
         used_timeout = TMO_MAX;
   end
endmodule // hlp_timeout_map

// File: rtl/hlp_config.sv
`timescale 1ns/1ps
module hlp_config
   import hlp_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
)
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Configuration load and host writes
   input  wire logic             serial_mem_mode,
   input  wire logic             mem_load_valid,
   input  wire logic [7:0]       mem_load_data,
   input  wire logic             host_wr_en,
   input  wire logic [7:0]       host_wr_data,
   output logic      [7:0]       cfg_read_data,
   // Link power management
   input  wire logic             force_accept_seen,
   input  wire logic             upstream_disconnect,
   input  wire logic [PORTS:0]   lpm_entry_want,
   output logic      [PORTS:0]   lpm_entry_allow,
   output logic                  lpm_supported,
   // Port power
   input  wire logic [PORTS-1:0] port_power_req,
   output logic      [PORTS-1:0] port_power_control_outputs,
   output logic                  power_status_report_en,
   // Downstream idle timeout
   input  wire logic [7:0]       host_timeout,
   output logic      [7:0]       used_timeout
);
   // -----------------------------------------------------------------
   // Configuration byte
   // -----------------------------------------------------------------
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   hlp_lpm_t   lpm_state;
   hlp_lpm_t   next_lpm_state;
   logic       link_low_power_disable;
   logic       power_switch_report_off;
   logic       grouped;
   logic       downstream_idle_timeout_override;

   // Load source picked by mode, only writable bits change
   always_comb begin
      next_cfg = cfg;
      if (serial_mem_mode && mem_load_valid)
         next_cfg = (cfg & ~CFG_WR_MASK) | (mem_load_data & CFG_WR_MASK);
      else if (!serial_mem_mode && host_wr_en)
         next_cfg = (cfg & ~CFG_WR_MASK) | (host_wr_data & CFG_WR_MASK);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         cfg <= CFG_RESET;
      else
         cfg <= next_cfg;
   end

   assign link_low_power_disable           = cfg[BIT_LPM_DIS];
   assign grouped                          = cfg[BIT_GROUPED];
   assign power_switch_report_off          = cfg[BIT_RPT_OFF];
   assign downstream_idle_timeout_override = cfg[BIT_TMO_OVR];

   // Read-back; fixed reserved bits forced regardless of storage
   always_comb begin
      cfg_read_data = cfg & CFG_WR_MASK;
      cfg_read_data[BIT_RESERVED_BIT_ONE] = CFG_FIX_ONE[BIT_RESERVED_BIT_ONE];
      cfg_read_data[BIT_RESERVED_BIT_ZERO] = 1'b0;
   end

   // -----------------------------------------------------------------
   // Link power state
   // -----------------------------------------------------------------
   // Forced state sticks; only disconnect (or reset) leaves it
   always_comb begin
      next_lpm_state = lpm_state;
      case (lpm_state)
         LPM_NORMAL: begin
            if (force_accept_seen && !upstream_disconnect)
               next_lpm_state = LPM_FORCED;
         end
         LPM_FORCED: begin
            if (upstream_disconnect)
               next_lpm_state = LPM_NORMAL;
         end
         default: next_lpm_state = LPM_NORMAL;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         lpm_state <= LPM_NORMAL;
      else
         lpm_state <= next_lpm_state;
   end

   assign lpm_supported = !link_low_power_disable || (lpm_state == LPM_FORCED);
   assign lpm_entry_allow = lpm_supported ? lpm_entry_want : '0;

   // -----------------------------------------------------------------
   // Port power switching
   // -----------------------------------------------------------------
   logic [PORTS-1:0] next_pwr;

   always_comb begin
      next_pwr = port_power_req;
      if (grouped) begin
         next_pwr = '0;
         next_pwr[0] = |port_power_req;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         port_power_control_outputs <= '0;
      else
         port_power_control_outputs <= next_pwr;
   end

   assign power_status_report_en = !power_switch_report_off;

   // -----------------------------------------------------------------
   // Timeout override
   // -----------------------------------------------------------------
   logic [7:0] mapped_timeout;

   hlp_timeout_map u_tmo (
      .override     (downstream_idle_timeout_override),
      .host_timeout (host_timeout),
      .used_timeout (mapped_timeout)
   );

   // Registered so the data output comes from a flip-flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         used_timeout <= TMO_ZERO;
      else
         used_timeout <= mapped_timeout;
   end
endmodule // hlp_config

// File: testbench/hlp_config_sva.sv
`timescale 1ns/1ps
module hlp_config_sva
   import hlp_pkg::*;
#(
   parameter int PORTS = NUM_PORTS
)
(
   // Clock and reset
   input wire logic             sys_clk,
   input wire logic             rst_n,
   // Observed
   input wire logic [7:0]       cfg_read_data,
   input wire logic [PORTS:0]   lpm_entry_allow,
   input wire logic             lpm_supported,
   input wire logic [PORTS-1:0] port_power_req,
   input wire logic [PORTS-1:0] port_power_control_outputs,
   input wire logic             power_status_report_en,
   input wire logic [7:0]       host_timeout,
   input wire logic [7:0]       used_timeout
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_fixed_bits: assert property (cfg_read_data[4] && !cfg_read_data[0])
      else $error("fixed bits wrong");
   a_report_en: assert property (power_status_report_en == !cfg_read_data[2])
      else $error("report enable wrong");
   a_lpm_support: assert property (!cfg_read_data[5] |-> lpm_supported)
      else $error("low power not supported");
   a_no_entry: assert property (!lpm_supported |-> lpm_entry_allow == '0)
      else $error("entry allowed while disabled");
   a_per_port: assert property (!cfg_read_data[3] |=> port_power_control_outputs == $past(port_power_req))
      else $error("per port power wrong");
   a_grouped_or: assert property (cfg_read_data[3] |=> port_power_control_outputs == PORTS'(|$past(port_power_req)))
      else $error("grouped power wrong");
   a_tmo_max: assert property (cfg_read_data[1] && host_timeout != 8'h00 |=> used_timeout == 8'hff)
      else $error("timeout not forced to max");
   a_tmo_zero: assert property (host_timeout == 8'h00 |=> used_timeout == 8'h00)
      else $error("zero timeout changed");
endmodule // hlp_config_sva

// File: testbench/hlp_cfg_src.sv
`timescale 1ns/1ps
module hlp_cfg_src (
   // Request
   input  wire logic       go,
   input  wire logic       mode,
   input  wire logic [7:0] d,
   // To the hub
   output logic            host_wr_en,
   output logic            mem_load_valid,
   output logic      [7:0] q
);
   assign host_wr_en     = go & ~mode;
   assign mem_load_valid = go & mode;
   // Idle data inverted so stale bytes never look valid
   assign q              = go ? d : ~d;
endmodule // hlp_cfg_src

// File: testbench/hlp_config_test.sv
`timescale 1ns/1ps
module hlp_config_test;
   import hlp_pkg::*;
   logic       sys_clk = 0, rst_n = 0, go = 0, md = 0, xm = 0, fa = 0, dc = 0, we, lv, sup, re;
   logic [7:0] d = 0, q, rd, ht = 0, ut;
   logic [4:0] w = 0, al;
   logic [3:0] rq = 0, po;
   int         n_mismatch = 0, total_checks = 0, cyc = 0, cfg = 16, frc = 0;
   bit [31:0]  s = 32'h3574;
   initial forever #50 sys_clk = ~sys_clk;
   // Hang guard, run needs about 125 cycles
   always @(posedge sys_clk) if (++cyc > 500) begin n_mismatch++; end_sim; end
   // Crossed mode sends the strobe down the port the hub must refuse
   hlp_cfg_src u_src (.go(go), .mode(md ^ xm), .d(d), .host_wr_en(we), .mem_load_valid(lv), .q(q));
   hlp_config u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .serial_mem_mode(md), .mem_load_valid(lv),
      .mem_load_data(q), .host_wr_en(we), .host_wr_data(q), .cfg_read_data(rd), .force_accept_seen(fa),
      .upstream_disconnect(dc), .lpm_entry_want(w), .lpm_entry_allow(al), .lpm_supported(sup),
      .port_power_req(rq), .port_power_control_outputs(po), .power_status_report_en(re),
      .host_timeout(ht), .used_timeout(ut));
   function automatic bit [31:0] xs(bit [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(logic [7:0] g, int e);
      total_checks++;
      if (g !== 8'(e)) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, 8'(e));
      end
   endtask
   task end_sim;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tk;
      @(posedge sys_clk);
      #1;
   endtask
   // Random writes in both modes, model kept as integers
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rst_n = 1;
      chk(rd, 'h10);
      for (int i = 0; i < 60; i++) begin
         s = xs(s);
         {go, md, d, ht, rq, w} = s[26:0];
         xm = s[27];
         fa = s[30:28] == 0;
         dc = s[31:28] == 1;
         if (go && !xm) cfg = 'h10 | (d & 'h2e);
         frc = dc ? 0 : (fa ? 1 : frc);
         tk;
         go = 0;
         fa = 0;
         dc = 0;
         chk(rd, cfg);
         chk(al, (!cfg[5] || frc) ? w : 0);
         chk(re, !cfg[2]);
         chk(sup, !cfg[5] || frc);
         tk;
         chk(po, cfg[3] ? |rq : rq);
         chk(ut, (cfg[1] && ht) ? 'hff : ht);
         $display("test %0d done", i);
      end
      // Mid-run reset must drop the forced state and the stored bits
      fa = 1;
      tk;
      fa = 0;
      chk(sup, 1);
      rst_n = 0;
      tk;
      rst_n = 1;
      frc = 0;
      cfg = 'h30;
      chk(rd, 'h10);
      {go, md, xm, d, w} = {3'b100, 8'h20, 5'h1f};
      tk;
      go = 0;
      chk(rd, cfg);
      chk(al, 0);
      chk(sup, 0);
      $display("test reset done");
      end_sim;
   end
endmodule // hlp_config_test
bind hlp_config hlp_config_sva #(.PORTS(PORTS)) u_sva (
   .sys_clk                    (sys_clk),
   .rst_n                      (rst_n),
   .cfg_read_data              (cfg_read_data),
   .lpm_entry_allow            (lpm_entry_allow),
   .lpm_supported              (lpm_supported),
   .port_power_req             (port_power_req),
   .port_power_control_outputs (port_power_control_outputs),
   .power_status_report_en     (power_status_report_en),
   .host_timeout               (host_timeout),
   .used_timeout               (used_timeout)
);
